// ---- logic/fcr_blink_reporter.sv ----
`timescale 1ns/1ps
// Summary of operation
// [R1] Key-on lights lamp two to three seconds
// [R2] After self-test, stored code keeps lamp lit
// [R3] Held test button plays stored codes out
// [R4] Each flash: 0.4 s on, 0.4 s off
// [R5] Lamp off 1.2 s between digits
// [R6] Lamp off 2.4 s between codes
// [R7] Each code flashed three times in turn
// [R8] Store holds up to six codes
// [R9] After last code, wrap to first code
// [R10] Codes kept and played in arrival order
// [R11] Detected malfunction records code, lights lamp
// [R12] Only power removal clears the store
// [R13] Bad cam pattern while running sets 53
// [R14] Lost cam: keep last injection order
// [R15] Throttle, pressure, pump range codes
// [R16] Oxygen, coolant, intake air range codes
// [R17] Speed, oil, crank, voltage codes
// [R18] Controller internal fault codes 54-56
// [R19] Oxygen out of band 10 s sets 32/42
// [R20] Pressure off estimate 2 s sets 14/24
// [R21] Digit shown as that many flashes
// [R22] Empty store plays code 11

module fcr_blink_reporter #(
  parameter int unsigned SELFTEST_CYC = fcr_pkg::SELFTEST_CYC,
  parameter int unsigned FLASH_CYC = fcr_pkg::FLASH_CYC,
  parameter int unsigned DIGIT_GAP_CYC = fcr_pkg::DIGIT_GAP_CYC,
  parameter int unsigned CODE_GAP_CYC = fcr_pkg::CODE_GAP_CYC,
  parameter int unsigned O2_HOLD_CYC = fcr_pkg::O2_HOLD_CYC,
  parameter int unsigned MAP_HOLD_CYC = fcr_pkg::MAP_HOLD_CYC
) (
  // Clock and reset; reset stands for power removal
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Operator pins, asynchronous
  input wire logic KEY_ON,
  input wire logic TEST_BUTTON,
  // Fault reports from the detectors, one bit per code
  input wire logic [fcr_pkg::NSRC-1:0] FAULT_IN,
  // Comparator levels: oxygen low, oxygen high, pressure low, pressure high
  input wire logic [fcr_pkg::NCMP-1:0] CMP_LEVEL,
  // Engine and cam position status
  input wire logic ENGINE_RUN,
  input wire logic CAM_SYNC,
  input wire logic CAM_PATTERN_BAD,
  input wire logic CAM_LOST,
  input wire logic INJ_STEP,
  // Lamp and status
  output logic FAULT_LAMP,
  output logic PLAYBACK_ACTIVE,
  output logic [2:0] CODE_COUNT,
  // Injection order
  output logic [1:0] INJ_CYL,
  output logic INJ_FALLBACK
);

  fcr_pkg::fcr_state_s q;
  fcr_pkg::fcr_state_s d;

  logic [fcr_pkg::NSRC-1:0] src;
  logic [fcr_pkg::NCMP-1:0][fcr_pkg::TW-1:0] hold_lim;
  logic [fcr_pkg::TW-1:0] pb_lim;
  logic pb_done;
  logic go;
  logic found;
  logic [4:0] sel;
  logic [7:0] cur_code;
  logic [7:0] nxt_code;
  logic [2:0] nxt_idx;
  logic wrap;

  // Hold limits per comparator lane
  always_comb begin
    hold_lim[0] = fcr_pkg::TW'(O2_HOLD_CYC - 1); // [R19]
    hold_lim[1] = fcr_pkg::TW'(O2_HOLD_CYC - 1); // [R19]
    hold_lim[2] = fcr_pkg::TW'(MAP_HOLD_CYC - 1); // [R20]
    hold_lim[3] = fcr_pkg::TW'(MAP_HOLD_CYC - 1); // [R20]
  end

  // Code under playback and the code that follows it
  always_comb begin
    wrap = (q.count == 3'h0) || (3'(q.idx + 3'h1) >= q.count); // [R9]
    nxt_idx = (q.rep == fcr_pkg::LAST_REP) ? (wrap ? 3'h0 : 3'(q.idx + 3'h1)) : q.idx;
    if (q.count == 3'h0) begin
      cur_code = fcr_pkg::CODE_ALL_OK; // [R22]
      nxt_code = fcr_pkg::CODE_ALL_OK; // [R22]
    end else begin
      cur_code = q.codes[q.idx]; // [R10]
      nxt_code = q.codes[nxt_idx]; // [R10]
    end
  end

  // Length of the current lamp phase
  always_comb begin
    case (q.pb_state)
      fcr_pkg::PB_ON: pb_lim = fcr_pkg::TW'(FLASH_CYC - 1); // [R4]
      fcr_pkg::PB_OFF: pb_lim = fcr_pkg::TW'(FLASH_CYC - 1); // [R4]
      fcr_pkg::PB_GAP: begin
        if (q.digit) begin
          pb_lim = fcr_pkg::TW'(CODE_GAP_CYC - 1); // [R6]
        end else begin
          pb_lim = fcr_pkg::TW'(DIGIT_GAP_CYC - 1); // [R5]
        end
      end
      default: pb_lim = '0;
    endcase
    pb_done = (q.pb_timer == pb_lim);
  end

  // Next state of the whole reporter
  always_comb begin
    d = q;
    src = FAULT_IN; // [R15] [R16] [R17] [R18]

    // Key and button pins pass two flops before anything reads them
    d.key_s1 = KEY_ON;
    d.key_s2 = q.key_s1;
    d.btn_s1 = TEST_BUTTON;
    d.btn_s2 = q.btn_s1;
    d.key_q = q.key_s2;

    // Self-test starts on each key-on and is dropped at key-off
    if (!q.key_s2) begin
      d.st_run = 1'b0;
      d.st_timer = '0;
    end else if (!q.key_q) begin
      d.st_run = 1'b1; // [R1]
      d.st_timer = '0;
    end else if (q.st_run) begin
      if (q.st_timer == fcr_pkg::TW'(SELFTEST_CYC - 1)) begin
        d.st_run = 1'b0; // [R1]
      end else begin
        d.st_timer = fcr_pkg::TW'(q.st_timer + 1'b1);
      end
    end

    // Persistence counters; a level break restarts the count
    for (int i = 0; i < fcr_pkg::NCMP; i++) begin
      if (!CMP_LEVEL[i]) begin
        d.hold[i] = '0;
      end else if (q.hold[i] == hold_lim[i]) begin
        src[fcr_pkg::CMP_SRC[i]] = 1'b1; // [R19] [R20]
      end else begin
        d.hold[i] = fcr_pkg::TW'(q.hold[i] + 1'b1);
      end
    end

    // A bad cam pattern only counts with the engine turning
    if (CAM_PATTERN_BAD && ENGINE_RUN) begin
      src[fcr_pkg::SRC_CAM_BAD] = 1'b1; // [R13]
    end

    // Each code is taken once; pending ones wait for their turn
    for (int i = 0; i < fcr_pkg::NSRC; i++) begin
      if (src[i] && !q.seen[i]) begin
        d.seen[i] = 1'b1; // [R11]
        d.pend[i] = 1'b1; // [R11]
      end
    end

    // Lowest pending source is written first, one per cycle
    found = 1'b0;
    sel = '0;
    for (int i = fcr_pkg::NSRC - 1; i >= 0; i--) begin
      if (q.pend[i]) begin
        found = 1'b1;
        sel = 5'(i);
      end
    end
    if (found) begin
      d.pend[sel] = 1'b0;
      // A full store drops later codes rather than reordering
      if (q.count < fcr_pkg::SLOTS_N) begin
        d.codes[q.count] = fcr_pkg::CODE_TABLE[sel]; // [R10] [R8]
        d.count = 3'(q.count + 3'h1); // [R8]
      end
    end

    // Playback is offered only after the self-test ends
    go = q.btn_s2 && q.key_s2 && !q.st_run; // [R3]
    if (!go) begin
      d.pb_state = fcr_pkg::PB_IDLE; // [R3]
      d.pb_timer = '0;
    end else begin
      d.pb_timer = pb_done ? '0 : fcr_pkg::TW'(q.pb_timer + 1'b1);
      case (q.pb_state)
        fcr_pkg::PB_IDLE: begin
          d.pb_state = fcr_pkg::PB_ON; // [R3]
          d.pb_timer = '0;
          d.idx = 3'h0;
          d.rep = 2'h0;
          d.digit = 1'b0;
          d.pulses = cur_code[7:4]; // [R21]
          if (q.count == 3'h0) begin
            d.pulses = fcr_pkg::CODE_ALL_OK[7:4]; // [R22]
          end else begin
            d.pulses = q.codes[0][7:4]; // [R21]
          end
        end
        fcr_pkg::PB_ON: begin
          if (pb_done) begin
            if (q.pulses > 4'h1) begin
              d.pb_state = fcr_pkg::PB_OFF; // [R4]
              d.pulses = 4'(q.pulses - 4'h1); // [R21]
            end else begin
              d.pb_state = fcr_pkg::PB_GAP; // [R5] [R6]
            end
          end
        end
        fcr_pkg::PB_OFF: begin
          if (pb_done) begin
            d.pb_state = fcr_pkg::PB_ON; // [R4]
          end
        end
        fcr_pkg::PB_GAP: begin
          if (pb_done) begin
            d.pb_state = fcr_pkg::PB_ON;
            if (!q.digit) begin
              d.digit = 1'b1;
              d.pulses = cur_code[3:0]; // [R21]
            end else begin
              d.digit = 1'b0;
              d.idx = nxt_idx; // [R7] [R9]
              d.rep = (q.rep == fcr_pkg::LAST_REP) ? 2'h0 : 2'(q.rep + 2'h1); // [R7]
              d.pulses = nxt_code[7:4]; // [R21]
            end
          end
        end
        default: d.pb_state = fcr_pkg::PB_IDLE;
      endcase
    end

    // Lamp: self-test wins, then playback, then the steady warning
    if (!q.key_s2) begin
      d.lamp = 1'b0;
    end else if (q.st_run) begin
      d.lamp = 1'b1; // [R1]
    end else if (go && (q.pb_state != fcr_pkg::PB_IDLE)) begin
      d.lamp = (q.pb_state == fcr_pkg::PB_ON); // [R3]
    end else begin
      d.lamp = (q.count != 3'h0); // [R2] [R11]
    end
    d.pb_active = go;

    // Cam sync sets the order; without it, steps carry the last order on
    if (CAM_SYNC && !CAM_LOST) begin
      d.cyl = 2'h0;
    end else if (INJ_STEP) begin
      d.cyl = 2'(q.cyl + 2'h1); // [R14]
    end
    d.fallback = CAM_LOST; // [R14]
  end

  // State register; codes survive everything but reset
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      q <= fcr_pkg::STATE_RESET; // [R12]
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign FAULT_LAMP = q.lamp;
  assign PLAYBACK_ACTIVE = q.pb_active;
  assign CODE_COUNT = q.count;
  assign INJ_CYL = q.cyl;
  assign INJ_FALLBACK = q.fallback;

endmodule : fcr_blink_reporter

// ---- logic/fcr_pkg.sv ----
package fcr_pkg;

  // Clock rate in kHz, so that a time in ms times this gives cycles
  localparam int unsigned CLK_KHZ = 125000;

  // Times in ms, as the lamp and detectors must see them
  localparam int unsigned SELFTEST_MS = 2500;
  localparam int unsigned FLASH_MS = 400;
  localparam int unsigned DIGIT_GAP_MS = 1200;
  localparam int unsigned CODE_GAP_MS = 2400;
  localparam int unsigned O2_HOLD_MS = 10000;
  localparam int unsigned MAP_HOLD_MS = 2000;

  // Derived cycle counts; 10 s is 1.25e9 cycles and still fits 31 bits
  localparam int unsigned SELFTEST_CYC = SELFTEST_MS * CLK_KHZ;
  localparam int unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;
  localparam int unsigned DIGIT_GAP_CYC = DIGIT_GAP_MS * CLK_KHZ;
  localparam int unsigned CODE_GAP_CYC = CODE_GAP_MS * CLK_KHZ;
  localparam int unsigned O2_HOLD_CYC = O2_HOLD_MS * CLK_KHZ;
  localparam int unsigned MAP_HOLD_CYC = MAP_HOLD_MS * CLK_KHZ;

  // Sizes
  localparam int unsigned TW = 31;
  localparam int unsigned SLOTS = 6;
  localparam logic [2:0] SLOTS_N = 3'h6;
  localparam logic [1:0] LAST_REP = 2'h2;
  localparam int unsigned NSRC = 21;
  localparam int unsigned NCMP = 4;

  // Fault source index of each detector that this block owns
  localparam int unsigned SRC_MAP_LOW = 2;
  localparam int unsigned SRC_MAP_HIGH = 3;
  localparam int unsigned SRC_O2_LOW = 6;
  localparam int unsigned SRC_O2_HIGH = 7;
  localparam int unsigned SRC_CAM_BAD = 15;

  // Comparator lanes: 0 oxygen low, 1 oxygen high, 2 pressure low, 3 pressure high
  localparam logic [NCMP-1:0][4:0] CMP_SRC = {5'h03, 5'h02, 5'h07, 5'h06};

  // Code shown when the store is empty
  localparam logic [7:0] CODE_ALL_OK = 8'h11;

  // Two BCD digits per source, index 0 at the right
  localparam logic [NSRC-1:0][7:0] CODE_TABLE = {
    8'h62, 8'h61, 8'h56, 8'h55, 8'h54, 8'h53, 8'h52, 8'h51, 8'h21,
    8'h45, 8'h35, 8'h43, 8'h33, 8'h42, 8'h32, 8'h41, 8'h31,
    8'h24, 8'h14, 8'h22, 8'h12};

  // Playback sequencer states
  typedef enum logic [3:0] {
    PB_IDLE = 4'h1,
    PB_ON = 4'h2,
    PB_OFF = 4'h4,
    PB_GAP = 4'h8
  } fcr_pb_state_e;

  // Whole state of the reporter
  typedef struct packed {
    logic key_s1;
    logic key_s2;
    logic key_q;
    logic btn_s1;
    logic btn_s2;
    logic st_run;
    logic [TW-1:0] st_timer;
    logic [SLOTS-1:0][7:0] codes;
    logic [2:0] count;
    logic [NSRC-1:0] seen;
    logic [NSRC-1:0] pend;
    logic [NCMP-1:0][TW-1:0] hold;
    fcr_pb_state_e pb_state;
    logic [TW-1:0] pb_timer;
    logic [3:0] pulses;
    logic digit;
    logic [1:0] rep;
    logic [2:0] idx;
    logic lamp;
    logic pb_active;
    logic [1:0] cyl;
    logic fallback;
  } fcr_state_s;

  localparam fcr_state_s STATE_RESET = '{pb_state: PB_IDLE, default: '0};

endpackage : fcr_pkg

// ---- sim/fcr_tech_model.sv ----
`timescale 1ns/1ps
module fcr_tech_model #(
  parameter int unsigned FLASH_CYC = 4
) (
  // Clock, reset and bench requests
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic key_cmd,
  input wire logic hold_cmd,
  // Lamp, key and button at the device
  input wire logic FAULT_LAMP,
  output logic KEY_ON,
  output logic TEST_BUTTON,
  // Decoded digit: flash count and the dark time after it
  output logic dig_stb,
  output logic [3:0] dig_cnt,
  output logic [7:0] dig_off
);
  logic lamp_q;
  logic [3:0] pulses;
  logic [7:0] off_run;
  // The technician holds key and button as plain levels
  assign KEY_ON = key_cmd;
  assign TEST_BUTTON = hold_cmd;
  // Count falls; a dark spell longer than a flash closes a digit at the next rise
  always_ff @(posedge SYS_CLK) begin
    lamp_q <= FAULT_LAMP;
    dig_stb <= 1'b0;
    if (!RESETN || !hold_cmd) begin
      pulses <= 4'h0;
      off_run <= 8'h0;
    end else if (FAULT_LAMP && !lamp_q) begin
      dig_stb <= (off_run > FLASH_CYC) && (pulses != 4'h0);
      dig_cnt <= pulses;
      dig_off <= off_run;
      if (off_run > FLASH_CYC) pulses <= 4'h0;
      off_run <= 8'h0;
    end else if (!FAULT_LAMP) begin
      if (lamp_q) pulses <= pulses + 4'h1;
      if (off_run != 8'hFF) off_run <= off_run + 8'h1;
    end
  end
endmodule : fcr_tech_model

// ---- sim/fcr_checker_properties.sv ----
`timescale 1ns/1ps
module fcr_checker #(
  parameter int unsigned SELFTEST_CYC = 20,
  parameter int unsigned FLASH_CYC = 4,
  parameter int unsigned DIGIT_GAP_CYC = 12,
  parameter int unsigned CODE_GAP_CYC = 24
) (
  // Clock, reset and inputs
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic KEY_ON,
  input wire logic CAM_SYNC,
  input wire logic CAM_LOST,
  input wire logic INJ_STEP,
  // Outputs judged
  input wire logic FAULT_LAMP,
  input wire logic PLAYBACK_ACTIVE,
  input wire logic [2:0] CODE_COUNT,
  input wire logic [1:0] INJ_CYL,
  input wire logic INJ_FALLBACK
);
  logic lamp_q;
  logic in_pb;
  logic [30:0] run;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Cycles at the present lamp level; in_pb marks a level begun inside playback
  always_ff @(posedge SYS_CLK) begin
    lamp_q <= FAULT_LAMP;
    if (!RESETN || FAULT_LAMP != lamp_q) run <= 31'h1;
    else run <= run + 31'h1;
    if (!RESETN) in_pb <= 1'b0;
    else if (FAULT_LAMP != lamp_q) in_pb <= PLAYBACK_ACTIVE;
  end
  // Held long enough for the lamp to follow, since the key passes two sync flops
  sequence s_armed;
    (KEY_ON && !PLAYBACK_ACTIVE && CODE_COUNT != 3'h0) [*8];
  endsequence
  sequence s_pb_edge;
    PLAYBACK_ACTIVE && in_pb;
  endsequence
  a_selftest_len: assert property ($fell(FAULT_LAMP) && !in_pb && CODE_COUNT == 3'h0 |->
    run == SELFTEST_CYC) else $error("self-test lamp time wrong");
  a_flash_on: assert property ($fell(FAULT_LAMP) ##0 s_pb_edge |-> run == FLASH_CYC)
    else $error("flash on time wrong");
  a_dark_time: assert property ($rose(FAULT_LAMP) ##0 s_pb_edge |->
    run == FLASH_CYC || run == DIGIT_GAP_CYC || run == CODE_GAP_CYC)
    else $error("dark time wrong");
  a_count_cap: assert property (CODE_COUNT <= 3'h6) else $error("too many codes");
  a_count_kept: assert property ($past(RESETN) |-> CODE_COUNT >= $past(CODE_COUNT))
    else $error("code store lost a code");
  a_lamp_steady: assert property (s_armed |-> FAULT_LAMP) else $error("lamp dark");
  a_fallback_flag: assert property ($past(RESETN) |-> INJ_FALLBACK == $past(CAM_LOST))
    else $error("fallback flag wrong");
  a_step_adv: assert property (INJ_STEP && !CAM_SYNC |=>
    INJ_CYL == $past(INJ_CYL) + 2'h1) else $error("injector index did not step");
  a_lost_order: assert property (CAM_SYNC && CAM_LOST && INJ_FALLBACK && !INJ_STEP |=>
    $stable(INJ_CYL)) else $error("lost cam moved index");
endmodule : fcr_checker
bind fcr_blink_reporter fcr_checker #(.SELFTEST_CYC(SELFTEST_CYC), .FLASH_CYC(FLASH_CYC),
  .DIGIT_GAP_CYC(DIGIT_GAP_CYC), .CODE_GAP_CYC(CODE_GAP_CYC)) u_props (.SYS_CLK(SYS_CLK),
  .RESETN(RESETN), .KEY_ON(KEY_ON), .CAM_SYNC(CAM_SYNC), .CAM_LOST(CAM_LOST),
  .INJ_STEP(INJ_STEP), .FAULT_LAMP(FAULT_LAMP), .PLAYBACK_ACTIVE(PLAYBACK_ACTIVE),
  .CODE_COUNT(CODE_COUNT), .INJ_CYL(INJ_CYL), .INJ_FALLBACK(INJ_FALLBACK));

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  localparam int unsigned DG = 12;
  localparam int unsigned CG = 24;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic key_cmd = 1'b0, hold_cmd = 1'b0, eng = 1'b0, c_sync = 1'b0, c_bad = 1'b0;
  logic c_lost = 1'b0, step = 1'b0;
  logic [fcr_pkg::NSRC-1:0] fault_in = '0;
  logic [fcr_pkg::NCMP-1:0] cmp_level = '0;
  logic key_on, button, lamp, pb, fallback, dig_stb;
  logic [2:0] count;
  logic [1:0] cyl;
  logic [3:0] dig_cnt;
  logic [7:0] dig_off;
  logic [11:0] dq[$];
  int err_total = 0;
  int total_checks = 0;
  // Codes in the order the bench raises them
  logic [7:0] order [6] = '{8'h53, 8'h32, 8'h14, 8'h21, 8'h12, 8'h54};
  // Counts shortened so a full playback cycle stays under 1300 cycles
  fcr_blink_reporter #(.SELFTEST_CYC(20), .FLASH_CYC(4), .DIGIT_GAP_CYC(DG),
    .CODE_GAP_CYC(CG), .O2_HOLD_CYC(10), .MAP_HOLD_CYC(5)) u_dut (.SYS_CLK(sys_clk),
    .RESETN(resetn), .KEY_ON(key_on), .TEST_BUTTON(button), .FAULT_IN(fault_in),
    .CMP_LEVEL(cmp_level), .ENGINE_RUN(eng), .CAM_SYNC(c_sync), .CAM_PATTERN_BAD(c_bad),
    .CAM_LOST(c_lost), .INJ_STEP(step), .FAULT_LAMP(lamp), .PLAYBACK_ACTIVE(pb),
    .CODE_COUNT(count), .INJ_CYL(cyl), .INJ_FALLBACK(fallback));
  fcr_tech_model #(.FLASH_CYC(4)) u_tech (.SYS_CLK(sys_clk), .RESETN(resetn),
    .key_cmd(key_cmd), .hold_cmd(hold_cmd), .FAULT_LAMP(lamp), .KEY_ON(key_on),
    .TEST_BUTTON(button), .dig_stb(dig_stb), .dig_cnt(dig_cnt), .dig_off(dig_off));
  always #4 sys_clk = ~sys_clk;
  // Keep each decoded digit: flash count high, dark time low
  always @(posedge sys_clk) if (dig_stb === 1'b1) dq.push_back({dig_cnt, dig_off});
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Hold the button until n digits are decoded, then let go
  task automatic play(int n);
    dq.delete();
    hold_cmd <= 1'b1;
    for (int i = 0; i < 5000 && dq.size() < n; i++) tick(1);
    #1 `CHK(pb, 1'b1)
    hold_cmd <= 1'b0;
    if (dq.size() < n) begin
      err_total++;
      wrap_up();
    end
    tick(8);
    #1 `CHK(pb, 1'b0)
  endtask : play
  task automatic chk_code(int k, logic [7:0] code);
    `CHK(dq[k], {code[7:4], 8'(DG)})
    `CHK(dq[k + 1], {code[3:0], 8'(CG)})
  endtask : chk_code
  // Key-on lamp test, then a dark lamp while nothing is stored
  task automatic t_selftest;
    int n;
    n = 0;
    key_cmd <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      tick(1);
      #1 n += int'(lamp === 1'b1);
    end
    `CHK(n, 20)
    `CHK(lamp, 1'b0)
    // An empty store still answers the button, with the all-clear code
    play(2);
    chk_code(0, 8'h11);
    $display("done selftest");
  endtask : t_selftest
  // Fault sources in a known order; a repeat and a seventh code are dropped
  task automatic t_record;
    int src [4] = '{12, 0, 0, 16};
    eng <= 1'b1;
    c_bad <= 1'b1;
    tick(1);
    c_bad <= 1'b0;
    tick(3);
    #1 `CHK(count, 3'h1)
    for (int h = 9; h < 11; h++) begin
      cmp_level <= 4'h1;
      tick(h);
      cmp_level <= 4'h0;
      tick(4);
      #1 `CHK(count, 3'(h - 8))
    end
    cmp_level <= 4'h4;
    tick(5);
    cmp_level <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      tick(4);
      fault_in[src[i]] <= 1'b1;
      tick(1);
      fault_in[src[i]] <= 1'b0;
    end
    tick(2);
    c_bad <= 1'b1;
    fault_in[19] <= 1'b1;
    tick(1);
    fault_in[19] <= 1'b0;
    c_bad <= 1'b0;
    tick(12);
    #1 `CHK(count, 3'h6)
    `CHK(lamp, 1'b1)
    play(38);
    for (int c = 0; c < 18; c++) begin
      chk_code(c * 2, order[c / 3]);
    end
    chk_code(36, order[0]);
    $display("done record");
  endtask : t_record
  // Injector order survives a lost cam signal
  // A sync alone, then a sync with a step, while lost: only the step may move the index
  task automatic t_cam;
    c_sync <= 1'b1;
    tick(1);
    c_sync <= 1'b0;
    step <= 1'b1;
    tick(2);
    step <= 1'b0;
    c_lost <= 1'b1;
    tick(2);
    c_sync <= 1'b1;
    tick(1);
    step <= 1'b1;
    tick(1);
    c_sync <= 1'b0;
    step <= 1'b0;
    c_lost <= 1'b0;
    #1 `CHK(fallback, 1'b1)
    `CHK(cyl, 2'h3)
    c_sync <= 1'b1;
    tick(1);
    c_sync <= 1'b0;
    tick(1);
    #1 `CHK(cyl, 2'h0)
    `CHK(fallback, 1'b0)
    $display("done cam");
  endtask : t_cam
  // Key off darkens the lamp but keeps codes; only power loss empties the store
  task automatic t_clear;
    key_cmd <= 1'b0;
    tick(8);
    #1 `CHK(lamp, 1'b0)
    `CHK(count, 3'h6)
    key_cmd <= 1'b1;
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(40);
    #1 `CHK(count, 3'h0)
    $display("done clear");
  endtask : t_clear
  initial begin
    tick(12);
    resetn <= 1'b1;
    t_selftest();
    t_record();
    t_cam();
    t_clear();
    wrap_up();
  end
endmodule : tb
